/* src/tpmdi_ctrl.v */
/*
 * Twisted-pair media control for one port: crossover hunt and forcing,
 * polarity correction, speed downshift, low-power idle, reduced-amplitude
 * 10 Mbit/s mode and ring-resiliency timing swap, with an Avalon-MM slave.
 * Assumes line-side status inputs synchronous to CORE_CLK, driven by the
 * port's DSP and autonegotiation logic.
 */
// Overview of operation
// [R1] crossover detection hunts wiring mappings at 10, 100 and 1000 Mbit/s
// [R2] inverted pair polarity is detected per pair and corrected internally
// [R3] crossover and polarity correction on after reset; control bits 5, 4 disable
// [R4] crossover and polarity outcome reported in the auxiliary status register
// [R5] crossover also runs forced 10/100 when bit 7 and AN enable are clear
// [R6] four mappings: normal, crossed, normal C/D swapped, crossed C/D unswapped
// [R7] wiring field 10 forces straight, 11 forces crossed, over automatic
// [R8] wiring field 00 follows automatic detection per control bits 7 and 5
// [R9] after set gigabit failures with downshift on, stop advertising gigabit
// [R10] downshift left without reset once a gigabit-capable partner appears
// [R11] downshift enable, count and status sit in bits 4:1, read and write; status bit 1 reads ds_state and ignores writes
// [R12] low-power idle cycles active and idle in 100 and 1000 Mbit/s modes
// [R13] writing 1 to bit 15 of the energy register enters reduced amplitude
// [R14] ring resiliency swaps timing reference, keeping master or slave role
// [R15] slave requests reference switch, freezes recovery, holds tx frequency
// [R16] master moves transmitter to recovered clock only after timing lock
// [R17] the partner must also implement ring resiliency for the swap to work
// [R18] clearing basic bit 12 disables AN; bits 6, 13, 8 force speed, duplex
// [R19] a link up clears the downshift failure counter
`timescale 1ns/1ps
`default_nettype none
`include "tpmdi_consts.vh"

module tpmdi_ctrl #(
  parameter HUNT_CYCLES = `TPMDI_HUNT_CYCLES
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RSTN,
  // avalon-mm slave
  input wire [5:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // line-side status
  input wire LINK_OK,
  input wire [1:0] LINK_SPEED,
  input wire [3:0] RX_POL_INV,
  input wire GIG_ATTEMPT_FAIL,
  input wire PARTNER_GIG,
  input wire TX_LPI_REQ,
  input wire MASTER_ROLE,
  input wire TIMING_LOCK,
  // media control
  output reg [1:0] PAIR_MAP,
  output reg [3:0] POL_CORR,
  output wire AN_ENABLE,
  output wire [1:0] FORCE_SPEED,
  output wire FORCE_FULL_DUPLEX,
  output reg ADV_1000,
  output reg LOW_POWER_IDLE,
  output reg TX_REDUCED_AMP,
  // ring resiliency
  output reg REF_SWITCH_REQ,
  output reg TR_FREEZE,
  output reg TX_FREQ_HOLD,
  output reg TX_CLK_RECOVERED,
  // interrupt
  output wire IRQ
);

  // ****************************************
  // register storage
  // ****************************************
  localparam [4:0] EV_LINK_UP = 5'h01;
  localparam [4:0] EV_LINK_DN = 5'h02;
  localparam [4:0] EV_DSHIFT = 5'h04;
  localparam [4:0] EV_POL = 5'h08;
  localparam [4:0] EV_RING = 5'h10;

  reg [15:0] basic;
  reg [15:0] phyctl;
  reg [1:0] wiring;
  reg [3:0] dshift;
  reg te_en;
  reg ring_en;
  reg [4:0] irq_stat;
  reg [4:0] irq_mask;
  reg ack;
  reg ds_state;
  reg [2:0] fail_cnt;
  reg link_q;
  reg [15:0] aux;
  wire [4:0] events;
  // a write lands at the edge where waitrequest is seen low
  wire wr = AVS_WRITE & ack;
  wire rd = AVS_READ & ~ack;

  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack;

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack <= 1'b0;
    end else begin
      ack <= (AVS_READ | AVS_WRITE) & ~ack;
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      basic <= `TPMDI_RST_BASIC;
      phyctl <= `TPMDI_RST_PHYCTL; // [R3]
      wiring <= `TPMDI_FORCE_AUTO;
      dshift <= `TPMDI_RST_DSHIFT;
      te_en <= 1'b0;
      ring_en <= 1'b0;
      irq_mask <= 5'h00;
    end else if (wr) begin
      case (AVS_ADDRESS)
        `TPMDI_OFS_BASIC: begin
          basic <= AVS_WRITEDATA[15:0]; // [R18]
        end
        `TPMDI_OFS_PHYCTL: begin
          phyctl <= AVS_WRITEDATA[15:0]; // [R3]
        end
        `TPMDI_OFS_WIRING: begin
          wiring <= AVS_WRITEDATA[`TPMDI_B_FORCE_LSB+1:`TPMDI_B_FORCE_LSB];
        end
        `TPMDI_OFS_DSHIFT: begin
          dshift <= AVS_WRITEDATA[4:1]; // [R11]
        end
        `TPMDI_OFS_EEE: begin
          te_en <= AVS_WRITEDATA[`TPMDI_B_TE_EN]; // [R13]
        end
        `TPMDI_OFS_RING: begin
          ring_en <= AVS_WRITEDATA[`TPMDI_B_RING_EN];
        end
        `TPMDI_OFS_IRQMASK: begin
          irq_mask <= AVS_WRITEDATA[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // set wins over a same-cycle write-one clear
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat <= 5'h00;
    end else if (wr && AVS_ADDRESS == `TPMDI_OFS_IRQSTAT) begin
      irq_stat <= (irq_stat & ~AVS_WRITEDATA[4:0]) | events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  assign IRQ = |(irq_stat & irq_mask);

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h00000000;
    end else if (rd) begin
      case (AVS_ADDRESS)
        `TPMDI_OFS_BASIC: AVS_READDATA <= {16'h0000, basic};
        `TPMDI_OFS_PHYCTL: AVS_READDATA <= {16'h0000, phyctl};
        `TPMDI_OFS_AUXSTAT: AVS_READDATA <= {16'h0000, aux}; // [R4]
        `TPMDI_OFS_WIRING: AVS_READDATA <= {28'h0000000, wiring, 2'h0};
        `TPMDI_OFS_DSHIFT: AVS_READDATA <= {27'h0000000, dshift[3:1], ds_state, 1'b0}; // [R11]
        `TPMDI_OFS_EEE: AVS_READDATA <= {16'h0000, te_en, 15'h0000};
        `TPMDI_OFS_RING: AVS_READDATA <= {31'h00000000, ring_en};
        `TPMDI_OFS_IRQSTAT: AVS_READDATA <= {27'h0000000, irq_stat};
        `TPMDI_OFS_IRQMASK: AVS_READDATA <= {27'h0000000, irq_mask};
        default: AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // speed and autonegotiation control
  // ****************************************
  assign AN_ENABLE = basic[`TPMDI_B_AN_EN]; // [R18]
  assign FORCE_SPEED = {basic[`TPMDI_B_SPEED_MSB], basic[`TPMDI_B_SPEED_LSB]}; // [R18]
  assign FORCE_FULL_DUPLEX = basic[`TPMDI_B_DUPLEX]; // [R18]

  // ****************************************
  // crossover hunt and wiring selection
  // ****************************************
  localparam [31:0] HUNT_LAST = HUNT_CYCLES - 1;
  reg [31:0] hunt_cnt;
  reg [1:0] hunt_map;
  reg [1:0] next_map;
  // auto crossover runs when enabled and, unless bit 7 clear, only with AN on
  wire auto_xover = ~phyctl[`TPMDI_B_XOVER_DIS] &
                    (AN_ENABLE | ~phyctl[`TPMDI_B_XOVER_FORCED]); // [R5] [R8]

  // mapping 0 normal, 1 crossed, 2 normal with C/D swap, 3 crossed no C/D swap
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hunt_cnt <= 32'h00000000;
      hunt_map <= `TPMDI_MAP_MDI;
    end else if (!auto_xover || LINK_OK) begin
      hunt_cnt <= 32'h00000000;
    end else if (hunt_cnt == HUNT_LAST) begin
      hunt_cnt <= 32'h00000000;
      hunt_map <= hunt_map + 2'h1; // [R1] [R6]
    end else begin
      hunt_cnt <= hunt_cnt + 32'h00000001;
    end
  end

  always @* begin
    case (wiring)
      `TPMDI_FORCE_MDI: next_map = `TPMDI_MAP_MDI; // [R7]
      `TPMDI_FORCE_MDIX: next_map = `TPMDI_MAP_MDIX; // [R7]
      default: next_map = auto_xover ? hunt_map : `TPMDI_MAP_MDI; // [R8]
    endcase
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PAIR_MAP <= `TPMDI_MAP_MDI;
    end else begin
      PAIR_MAP <= next_map; // [R1]
    end
  end

  // ****************************************
  // polarity correction
  // ****************************************
  wire [3:0] next_pol = phyctl[`TPMDI_B_POL_DIS] ? 4'h0 : RX_POL_INV; // [R2] [R3]

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      POL_CORR <= 4'h0;
    end else begin
      POL_CORR <= next_pol; // [R2]
    end
  end

  always @* begin
    aux = 16'h0000;
    aux[`TPMDI_B_ST_MDIX] = PAIR_MAP[0]; // [R4]
    aux[`TPMDI_B_ST_CDSWAP] = PAIR_MAP[1]; // [R4]
    aux[`TPMDI_B_ST_POL_LSB+3:`TPMDI_B_ST_POL_LSB] = POL_CORR; // [R4]
  end

  // ****************************************
  // speed downshift
  // ****************************************
  wire [2:0] fail_limit = `TPMDI_DS_BASE + {1'b0, dshift[2:1]};
  wire ds_en = dshift[3];
  wire ds_hit = ds_en & ~ds_state & GIG_ATTEMPT_FAIL &
                ({1'b0, fail_cnt} + 4'h1 >= {1'b0, fail_limit});

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fail_cnt <= 3'h0;
      ds_state <= 1'b0;
    end else begin
      if (LINK_OK) begin
        fail_cnt <= 3'h0; // [R19]
      end else if (ds_hit) begin
        fail_cnt <= 3'h0;
      end else if (ds_en && GIG_ATTEMPT_FAIL && fail_cnt != 3'h7) begin
        fail_cnt <= fail_cnt + 3'h1;
      end
      if (!ds_en || PARTNER_GIG) begin
        ds_state <= 1'b0; // [R10]
      end else if (ds_hit) begin
        ds_state <= 1'b1; // [R9]
      end
    end
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ADV_1000 <= 1'b1;
    end else begin
      ADV_1000 <= ~ds_state; // [R9]
    end
  end

  // ****************************************
  // energy saving
  // ****************************************
  wire lpi_speed = (LINK_SPEED == `TPMDI_SPD_100) | (LINK_SPEED == `TPMDI_SPD_1000);

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      LOW_POWER_IDLE <= 1'b0;
      TX_REDUCED_AMP <= 1'b0;
    end else begin
      LOW_POWER_IDLE <= LINK_OK & lpi_speed & TX_LPI_REQ; // [R12]
      TX_REDUCED_AMP <= te_en; // [R13]
    end
  end

  // ****************************************
  // ring resiliency
  // ****************************************
  localparam [1:0] RR_IDLE = 2'h0;
  localparam [1:0] RR_SLAVE = 2'h1;
  localparam [1:0] RR_MWAIT = 2'h2;
  localparam [1:0] RR_MRECV = 2'h3;
  reg [1:0] rr_state;
  reg [1:0] next_rr;
  // the role input is only read, never driven: the negotiated role stays
  wire rr_go = ring_en & LINK_OK & (LINK_SPEED == `TPMDI_SPD_1000); // [R14] [R17]

  always @* begin
    next_rr = rr_state;
    case (rr_state)
      RR_IDLE: begin
        if (rr_go) begin
          next_rr = MASTER_ROLE ? RR_MWAIT : RR_SLAVE; // [R14]
        end
      end
      RR_SLAVE: begin
        if (!rr_go) begin
          next_rr = RR_IDLE;
        end
      end
      RR_MWAIT: begin
        if (!rr_go) begin
          next_rr = RR_IDLE;
        end else if (TIMING_LOCK) begin
          next_rr = RR_MRECV; // [R16]
        end
      end
      RR_MRECV: begin
        if (!rr_go) begin
          next_rr = RR_IDLE;
        end
      end
      default: next_rr = RR_IDLE;
    endcase
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rr_state <= RR_IDLE;
      REF_SWITCH_REQ <= 1'b0;
      TR_FREEZE <= 1'b0;
      TX_FREQ_HOLD <= 1'b0;
      TX_CLK_RECOVERED <= 1'b0;
    end else begin
      rr_state <= next_rr;
      REF_SWITCH_REQ <= (next_rr == RR_SLAVE); // [R15]
      TR_FREEZE <= (next_rr == RR_SLAVE); // [R15]
      TX_FREQ_HOLD <= (next_rr == RR_SLAVE); // [R15]
      // single registered select of the recovered transmit clock
      TX_CLK_RECOVERED <= (next_rr == RR_MRECV); // [R16]
    end
  end

  // ****************************************
  // interrupt events
  // ****************************************
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      link_q <= 1'b0;
    end else begin
      link_q <= LINK_OK;
    end
  end

  assign events = ((LINK_OK & ~link_q) ? EV_LINK_UP : 5'h00) |
                  ((~LINK_OK & link_q) ? EV_LINK_DN : 5'h00) |
                  (ds_hit ? EV_DSHIFT : 5'h00) |
                  ((next_pol != POL_CORR) ? EV_POL : 5'h00) |
                  ((next_rr != rr_state && next_rr != RR_IDLE) ? EV_RING : 5'h00);

endmodule
`default_nettype wire

/* src/tpmdi_consts.vh */
/*
 * Constants of the twisted-pair media control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes a 32-bit Avalon-MM register bus and a 200 MHz core clock.
 */
`ifndef TPMDI_CONSTS_VH
`define TPMDI_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define TPMDI_OFS_BASIC 6'h00
`define TPMDI_OFS_PHYCTL 6'h04
`define TPMDI_OFS_AUXSTAT 6'h08
`define TPMDI_OFS_WIRING 6'h0C
`define TPMDI_OFS_DSHIFT 6'h10
`define TPMDI_OFS_EEE 6'h14
`define TPMDI_OFS_RING 6'h18
`define TPMDI_OFS_IRQSTAT 6'h1C
`define TPMDI_OFS_IRQMASK 6'h20

// ****************************************
// field positions
// ****************************************
`define TPMDI_B_SPEED_LSB 6
`define TPMDI_B_DUPLEX 8
`define TPMDI_B_AN_EN 12
`define TPMDI_B_SPEED_MSB 13
`define TPMDI_B_XOVER_FORCED 7
`define TPMDI_B_XOVER_DIS 5
`define TPMDI_B_POL_DIS 4
`define TPMDI_B_ST_MDIX 13
`define TPMDI_B_ST_CDSWAP 12
`define TPMDI_B_ST_POL_LSB 8
`define TPMDI_B_FORCE_LSB 2
`define TPMDI_B_DS_EN 4
`define TPMDI_B_DS_CNT_LSB 2
`define TPMDI_B_DS_STAT 1
`define TPMDI_B_TE_EN 15
`define TPMDI_B_RING_EN 0

// ****************************************
// reset values and codes
// ****************************************
`define TPMDI_RST_BASIC 16'h1140
`define TPMDI_RST_PHYCTL 16'h0080
`define TPMDI_RST_DSHIFT 4'h0
`define TPMDI_FORCE_AUTO 2'h0
`define TPMDI_FORCE_MDI 2'h2
`define TPMDI_FORCE_MDIX 2'h3
`define TPMDI_MAP_MDI 2'h0
`define TPMDI_MAP_MDIX 2'h1
`define TPMDI_DS_BASE 3'h2
`define TPMDI_SPD_100 2'h1
`define TPMDI_SPD_1000 2'h2

// ****************************************
// timing
// ****************************************
`define TPMDI_CLK_MHZ 200
`define TPMDI_HUNT_US 100
`define TPMDI_HUNT_CYCLES (`TPMDI_HUNT_US * `TPMDI_CLK_MHZ)

`endif

/* bench/tpmdi_ctrl_assertions.sv */
/* port-level checks of the twisted-pair media control block.
   assumes it is bound onto tpmdi_ctrl with one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tpmdi_assertions (
  // clock and bus
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic AVS_WAITREQUEST,
  // line side
  input wire logic LINK_OK,
  input wire logic [1:0] LINK_SPEED,
  input wire logic [3:0] RX_POL_INV,
  input wire logic GIG_ATTEMPT_FAIL,
  input wire logic PARTNER_GIG,
  input wire logic TX_LPI_REQ,
  input wire logic MASTER_ROLE,
  input wire logic TIMING_LOCK,
  // media and ring
  input wire logic [1:0] PAIR_MAP,
  input wire logic [3:0] POL_CORR,
  input wire logic ADV_1000,
  input wire logic LOW_POWER_IDLE,
  input wire logic TX_REDUCED_AMP,
  input wire logic REF_SWITCH_REQ,
  input wire logic TR_FREEZE,
  input wire logic TX_FREQ_HOLD,
  input wire logic TX_CLK_RECOVERED
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wire logic wr_go = AVS_WRITE && !AVS_WAITREQUEST;
  wire logic lpi_ok = LINK_OK && TX_LPI_REQ && (LINK_SPEED == 2'h1 || LINK_SPEED == 2'h2);
  a_bus_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("waitrequest held past one cycle");
  a_lpi_entry: assert property (lpi_ok |=> LOW_POWER_IDLE)
    else $error("low-power idle not entered");
  a_lpi_cause: assert property (LOW_POWER_IDLE |-> $past(lpi_ok))
    else $error("low-power idle without cause");
  a_amp_write: assert property (wr_go && AVS_ADDRESS == 6'h14 |-> ##2 TX_REDUCED_AMP == $past(AVS_WRITEDATA[15], 2))
    else $error("reduced amplitude does not follow write");
  a_wiring_force: assert property (wr_go && AVS_ADDRESS == 6'h0C && AVS_WRITEDATA[3]
    |-> ##2 PAIR_MAP == {1'b0, $past(AVS_WRITEDATA[2], 2)})
    else $error("forced wiring not applied");
  a_pol_track: assert property (POL_CORR != 4'h0 |-> POL_CORR == $past(RX_POL_INV))
    else $error("polarity correction differs from detection");
  a_ds_fall: assert property ($fell(ADV_1000) |-> $past(GIG_ATTEMPT_FAIL) || $past(GIG_ATTEMPT_FAIL, 2))
    else $error("gigabit advert dropped without failure");
  a_ds_exit: assert property (!ADV_1000 && PARTNER_GIG |-> ##[1:2] ADV_1000)
    else $error("downshift not left for gigabit partner");
  a_ring_slave: assert property (REF_SWITCH_REQ |-> TR_FREEZE && TX_FREQ_HOLD && !TX_CLK_RECOVERED)
    else $error("slave swap outputs inconsistent");
  a_ring_lock: assert property ($rose(TX_CLK_RECOVERED) |-> $past(TIMING_LOCK) && $past(MASTER_ROLE))
    else $error("recovered clock taken before lock");
endmodule
bind tpmdi_ctrl tpmdi_assertions chk (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .LINK_OK(LINK_OK), .LINK_SPEED(LINK_SPEED),
  .RX_POL_INV(RX_POL_INV), .GIG_ATTEMPT_FAIL(GIG_ATTEMPT_FAIL), .PARTNER_GIG(PARTNER_GIG),
  .TX_LPI_REQ(TX_LPI_REQ), .MASTER_ROLE(MASTER_ROLE), .TIMING_LOCK(TIMING_LOCK), .PAIR_MAP(PAIR_MAP),
  .POL_CORR(POL_CORR), .ADV_1000(ADV_1000), .LOW_POWER_IDLE(LOW_POWER_IDLE), .TX_REDUCED_AMP(TX_REDUCED_AMP),
  .REF_SWITCH_REQ(REF_SWITCH_REQ), .TR_FREEZE(TR_FREEZE), .TX_FREQ_HOLD(TX_FREQ_HOLD),
  .TX_CLK_RECOVERED(TX_CLK_RECOVERED));
`default_nettype wire

/* bench/tpmdi_partner.sv */
/* remote link partner seen through the port's line-side status.
   assumes the bench calls its tasks; it reacts to the local advert. */
`timescale 1ns/1ps
`default_nettype none
module tpmdi_partner #(parameter int LOCK_DELAY = 20) (
  // clock and local advert
  input wire logic CORE_CLK,
  input wire logic ADV_1000,
  // line-side status
  output var logic LINK_OK = 1'b0,
  output var logic [1:0] LINK_SPEED = 2'h0,
  output var logic [3:0] RX_POL_INV = 4'h0,
  output var logic GIG_ATTEMPT_FAIL = 1'b0,
  output var logic PARTNER_GIG = 1'b0,
  output var logic MASTER_ROLE = 1'b0,
  output var logic TIMING_LOCK = 1'b0
);
  int lock_cnt = 0;
  // gigabit only when the port still advertises it
  task automatic link(input logic ok, input logic [1:0] spd, input logic m);
    @(posedge CORE_CLK);
    LINK_OK <= ok;
    LINK_SPEED <= (spd == 2'h2 && !ADV_1000) ? 2'h1 : spd;
    MASTER_ROLE <= m;
  endtask
  task automatic pol(input logic [3:0] p);
    @(posedge CORE_CLK);
    RX_POL_INV <= p;
  endtask
  task automatic fail();
    @(posedge CORE_CLK);
    GIG_ATTEMPT_FAIL <= 1'b1;
    @(posedge CORE_CLK);
    GIG_ATTEMPT_FAIL <= 1'b0;
  endtask
  task automatic gig();
    @(posedge CORE_CLK);
    PARTNER_GIG <= 1'b1;
    @(posedge CORE_CLK);
    PARTNER_GIG <= 1'b0;
  endtask
  // far end joins the timing swap and locks after a delay
  always @(posedge CORE_CLK) begin
    lock_cnt <= (MASTER_ROLE && LINK_OK && LINK_SPEED == 2'h2) ? lock_cnt + 1 : 0;
    TIMING_LOCK <= lock_cnt >= LOCK_DELAY;
  end
endmodule
`default_nettype wire

/* bench/twisted_pair_mdi_control_bench.sv */
/* self-checking bench of the twisted-pair media control block.
   assumes tpmdi_ctrl, its checker and the partner model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module twisted_pair_mdi_control_bench;
  typedef struct {int sel; logic [31:0] exp;} tpmdi_note_t;
  logic CORE_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [5:0] AVS_ADDRESS = 6'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic TX_LPI_REQ = 1'b0;
  logic obs = 1'b0;
  logic [31:0] lfsr_st = 32'hF07437D3;
  logic [3:0] pv;
  wire logic [31:0] AVS_READDATA;
  wire logic [1:0] LINK_SPEED, PAIR_MAP, FORCE_SPEED;
  wire logic [3:0] RX_POL_INV, POL_CORR;
  wire logic AVS_WAITREQUEST, LINK_OK, GIG_ATTEMPT_FAIL, PARTNER_GIG, MASTER_ROLE, TIMING_LOCK;
  wire logic AN_ENABLE, FORCE_FULL_DUPLEX, ADV_1000, LOW_POWER_IDLE, TX_REDUCED_AMP, IRQ;
  wire logic REF_SWITCH_REQ, TR_FREEZE, TX_FREQ_HOLD, TX_CLK_RECOVERED;
  int n_fail = 0;
  int check_count = 0;
  int i;
  tpmdi_note_t notes[$];
  tpmdi_note_t cur;
  string nm [9] = '{"readdata", "PAIR_MAP", "POL_CORR", "ADV_1000", "LOW_POWER_IDLE", "TX_REDUCED_AMP",
    "ring", "IRQ", "basic"};
  tpmdi_ctrl #(.HUNT_CYCLES(8)) uut (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .LINK_OK(LINK_OK), .LINK_SPEED(LINK_SPEED), .RX_POL_INV(RX_POL_INV), .GIG_ATTEMPT_FAIL(GIG_ATTEMPT_FAIL),
    .PARTNER_GIG(PARTNER_GIG), .TX_LPI_REQ(TX_LPI_REQ), .MASTER_ROLE(MASTER_ROLE), .TIMING_LOCK(TIMING_LOCK),
    .PAIR_MAP(PAIR_MAP), .POL_CORR(POL_CORR), .AN_ENABLE(AN_ENABLE), .FORCE_SPEED(FORCE_SPEED),
    .FORCE_FULL_DUPLEX(FORCE_FULL_DUPLEX), .ADV_1000(ADV_1000), .LOW_POWER_IDLE(LOW_POWER_IDLE),
    .TX_REDUCED_AMP(TX_REDUCED_AMP), .REF_SWITCH_REQ(REF_SWITCH_REQ), .TR_FREEZE(TR_FREEZE),
    .TX_FREQ_HOLD(TX_FREQ_HOLD), .TX_CLK_RECOVERED(TX_CLK_RECOVERED), .IRQ(IRQ));
  tpmdi_partner peer (
    .CORE_CLK(CORE_CLK), .ADV_1000(ADV_1000), .LINK_OK(LINK_OK), .LINK_SPEED(LINK_SPEED),
    .RX_POL_INV(RX_POL_INV), .GIG_ATTEMPT_FAIL(GIG_ATTEMPT_FAIL), .PARTNER_GIG(PARTNER_GIG),
    .MASTER_ROLE(MASTER_ROLE), .TIMING_LOCK(TIMING_LOCK));
  always #2.5 CORE_CLK = ~CORE_CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] pick(input int s);
    case (s)
      0: pick = AVS_READDATA;
      1: pick = {30'h0, PAIR_MAP};
      2: pick = {28'h0, POL_CORR};
      3: pick = {31'h0, ADV_1000};
      4: pick = {31'h0, LOW_POWER_IDLE};
      5: pick = {31'h0, TX_REDUCED_AMP};
      6: pick = {28'h0, REF_SWITCH_REQ, TR_FREEZE, TX_FREQ_HOLD, TX_CLK_RECOVERED};
      7: pick = {31'h0, IRQ};
      default: pick = {28'h0, AN_ENABLE, FORCE_SPEED, FORCE_FULL_DUPLEX};
    endcase
  endfunction
  task automatic summarize();
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge CORE_CLK);
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge CORE_CLK);
      if (!AVS_WAITREQUEST) break;
    end
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (k == 20) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    notes.push_back('{0, e});
    bus(1'b1, a, 32'h0);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic look(input int s, input logic [31:0] e);
    repeat (2) @(posedge CORE_CLK);
    notes.push_back('{s, e});
    obs <= 1'b1;
    @(posedge CORE_CLK);
    obs <= 1'b0;
  endtask
  task automatic wait_map(input logic [1:0] v);
    int k;
    for (k = 0; k < 60; k++) begin
      @(posedge CORE_CLK);
      if (PAIR_MAP === v) break;
    end
    if (k == 60) begin
      n_fail++;
      summarize();
    end
  endtask
  // result watcher: oldest note against what the outputs show
  always @(posedge CORE_CLK) begin
    if ((AVS_READ && !AVS_WAITREQUEST) || obs) begin
      cur = notes.pop_front();
      check_count++;
      if (pick(cur.sel) !== cur.exp) begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", nm[cur.sel], cur.exp, pick(cur.sel));
      end
    end
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_fail++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    rd(6'h00, 32'h1140);
    rd(6'h04, 32'h80);
    rd(6'h3C, 32'h0);
    look(8, 32'hB);
    for (i = 2; i < 4; i++) begin
      wr(6'h0C, {28'h0, i[1:0], 2'h0});
      look(1, {31'h0, i[0]});
    end
    wr(6'h0C, 32'h0);
    for (i = 0; i < 4; i++) begin
      wait_map(i[1:0]);
    end
    peer.link(1'b1, 2'h2, 1'b0);
    rd(6'h08, 32'h3000);
    peer.link(1'b0, 2'h0, 1'b0);
    wr(6'h04, 32'h0);
    wr(6'h00, 32'h140);
    look(8, 32'h3);
    wait_map(2'h0);
    wait_map(2'h1);
    wr(6'h00, 32'h1140);
    wr(6'h20, 32'h8);
    lfsr_st = lfsr(lfsr_st);
    pv = lfsr_st[3:0] | 4'h1;
    peer.pol(pv);
    look(2, {28'h0, pv});
    look(7, 32'h1);
    wr(6'h1C, 32'h8);
    look(7, 32'h0);
    wr(6'h20, 32'h0);
    peer.pol(~pv);
    look(7, 32'h0);
    wr(6'h04, 32'h90);
    look(2, 32'h0);
    wr(6'h10, 32'h10);
    peer.fail();
    peer.link(1'b1, 2'h1, 1'b0);
    peer.link(1'b0, 2'h0, 1'b0);
    peer.fail();
    look(3, 32'h1);
    peer.fail();
    look(3, 32'h0);
    rd(6'h10, 32'h12);
    peer.gig();
    look(3, 32'h1);
    peer.link(1'b1, 2'h2, 1'b0);
    TX_LPI_REQ <= 1'b1;
    look(4, 32'h1);
    peer.link(1'b1, 2'h0, 1'b0);
    look(4, 32'h0);
    wr(6'h14, 32'h8000);
    look(5, 32'h1);
    wr(6'h18, 32'h1);
    peer.link(1'b1, 2'h2, 1'b0);
    look(6, 32'hE);
    peer.link(1'b0, 2'h0, 1'b1);
    peer.link(1'b1, 2'h2, 1'b1);
    look(6, 32'h0);
    repeat (30) @(posedge CORE_CLK);
    look(6, 32'h1);
    @(posedge CORE_CLK);
    summarize();
  end
endmodule
`default_nettype wire
